/* File: gst_regs.sv */
// global strobe, test input, sync and read order register bank
`include "gst_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module gst_regs (
    // clock, reset, enable
    input  wire logic                       mclk_i,
    input  wire logic                       resetn_i,
    input  wire logic                       ce_i,
    // global write location port
    input  wire logic                       wr_en_i,
    input  wire logic [15:0]                wr_addr_i,
    input  wire logic [31:0]                wr_data_i,
    // readback port
    input  wire logic [15:0]                rd_addr_i,
    output logic      [31:0]                rd_data_o,
    // level detector
    input  wire logic                       ld_sample_i,
    input  wire logic [15:0]                ld_interval_i,
    input  wire logic                       ld_free_run_i,
    output logic                            ld_clear_o,
    output logic                            ld_accum_en_o,
    output logic      [15:0]                status_o,
    // host test input
    input  wire logic [3:0]                 eni_strobe_sel_i,
    input  wire logic [3:0]                 eni_level_i,
    output logic      [15:0]                test_value_o,
    output logic      [3:0]                 input_enable_strobe_o,
    // sync
    output logic                            sync_output_pin_o,
    input  wire logic                       sync_input_pin_i,
    output logic                            sync_in_o,
    // self test
    input  wire logic                       bist_done_i,
    input  wire logic [15:0]                bist_sig_i,
    output logic      [15:0]                expected_sig_o,
    // read order selection
    input  wire logic [4:0]                 slot_sel_i,
    input  wire gst_pkg::gst_chan_data_t    chan_data_i [4],
    output logic      [15:0]                fifo_word_o
);
    import gst_pkg::*;

    // address decode, strobes act on the write event alone
    // data ignored on strobes
    wire wr_start = wr_en_i && (wr_addr_i == `GST_ADDR_LD_START);
    wire wr_tval  = wr_en_i && (wr_addr_i == `GST_ADDR_TEST_VAL);
    wire wr_eni   = wr_en_i && (wr_addr_i == `GST_ADDR_TEST_ENI);
    wire wr_sync  = wr_en_i && (wr_addr_i == `GST_ADDR_SYNC_OUT);
    wire wr_loop  = wr_en_i && (wr_addr_i == `GST_ADDR_SYNC_LOOP);
    wire wr_sig   = wr_en_i && (wr_addr_i == `GST_ADDR_SIGNATURE);
    wire wr_slot  = wr_en_i && (wr_addr_i[15:5] == `GST_SLOT_BASE_HI);

    // level detector interval sequencer
    gst_ld_state_t state_q;
    gst_ld_state_t state_d;
    logic [16:0]   count_q;
    logic [16:0]   count_d;
    logic          done_q;
    wire           expire = (state_q == GST_LD_RUN) && ld_sample_i
                            && (count_q == `GST_LD_LAST);
    wire [16:0]    count_load = {1'b0, ld_interval_i} + `GST_LD_EXTRA;

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            GST_LD_IDLE: begin
                state_d = GST_LD_IDLE;
            end
            GST_LD_RUN: begin
                if (expire) begin
                    state_d = GST_LD_DONE;
                end else if (ld_sample_i) begin
                    count_d = count_q - `GST_LD_LAST;
                end
            end
            GST_LD_DONE: begin
                state_d = GST_LD_DONE;
            end
            default: begin
                state_d = GST_LD_IDLE;
            end
        endcase
        if (wr_start) begin
            state_d = GST_LD_RUN;
            count_d = count_load;
        end
    end

    // done flag: expiry wins over the clearing start
    // expiry sets status
    wire done_d = expire || (done_q && !wr_start);
    wire accum_d = (state_d == GST_LD_RUN) || ld_free_run_i;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q       <= GST_LD_IDLE;
            count_q       <= 17'h00000;
            done_q        <= 1'b0;
            ld_clear_o    <= 1'b0;
            ld_accum_en_o <= 1'b0;
        end else if (ce_i) begin
            state_q       <= state_d;
            count_q       <= count_d;
            done_q        <= done_d;
            ld_clear_o    <= wr_start;
            ld_accum_en_o <= accum_d;
        end
    end

    // status word shows the done flag
    always_comb begin
        status_o = 16'h0000;
        status_o[`GST_STATUS_DONE_BIT] = done_q;
    end

    // test input value and per-channel enable
    // level or strobe select
    wire [3:0] eni_d = (eni_strobe_sel_i & {4{wr_eni}})
                       | (~eni_strobe_sel_i & eni_level_i);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            test_value_o          <= 16'h0000;
            input_enable_strobe_o <= 4'h0;
        end else if (ce_i) begin
            if (wr_tval) begin
                test_value_o <= wr_data_i[15:0];
            end
            input_enable_strobe_o <= eni_d;
        end
    end

    // sync pin synchroniser, three stages; a legal sync is one clock wide,
    // so the third stage is taken as it stands instead of waiting for
    // two stages to agree, which would swallow every sync pulse
    logic [2:0] sync_sy_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_sy_q         <= 3'h0;
            sync_output_pin_o <= 1'b0;
            sync_in_o         <= 1'b0;
        end else if (ce_i) begin
            sync_sy_q <= {sync_sy_q[1:0], sync_input_pin_i};
            sync_output_pin_o <= wr_sync || wr_loop;
            sync_in_o <= sync_sy_q[2] || wr_loop;
        end
    end

    // self test signature: low half host, high half device
    logic [15:0] sig_hi_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            expected_sig_o <= 16'h0000;
            sig_hi_q       <= 16'h0000;
        end else if (ce_i) begin
            if (wr_sig) begin
                expected_sig_o <= wr_data_i[15:0];
            end
            if (bist_done_i) begin
                sig_hi_q <= bist_sig_i;
            end
        end
    end

    // read order slots
    logic [4:0] slot_q [32];

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int k = 0; k < 32; k++) begin
                slot_q[k] <= 5'h00;
            end
        end else if (ce_i && wr_slot) begin
            slot_q[wr_addr_i[4:0]] <= wr_data_i[4:0];
        end
    end

    // data type selection for the current slot
    wire [4:0]           cur_slot = slot_q[slot_sel_i];
    wire [1:0]           cur_chan = cur_slot[`GST_CHAN_MSB:`GST_CHAN_LSB];
    wire [2:0]           cur_type = cur_slot[`GST_DT_MSB:0];
    wire gst_chan_data_t cd       = chan_data_i[cur_chan];
    logic [15:0]         fifo_d;

    always_comb begin
        case (cur_type)
            `GST_DT_I_HI:   fifo_d = cd.i_path[23:8];
            `GST_DT_I_LO:   fifo_d = {cd.i_path[7:0], 8'h00};
            `GST_DT_Q_HI:   fifo_d = cd.q_path[23:8];
            `GST_DT_Q_LO:   fifo_d = {cd.q_path[7:0], 8'h00};
            `GST_DT_MAG_HI: fifo_d = cd.magnitude[23:8];
            `GST_DT_MAG_LO: fifo_d = {cd.magnitude[7:0], 8'h00};
            `GST_DT_PHASE:  fifo_d = cd.phase;
            `GST_DT_AGC:    fifo_d = cd.agc_gain;
            default:        fifo_d = 16'h0000;
        endcase
    end

    // readback mux, unmapped locations read zero
    wire rd_slot = (rd_addr_i[15:5] == `GST_SLOT_BASE_HI);
    wire [31:0] rd_d =
        (rd_addr_i == `GST_ADDR_TEST_VAL)  ? {16'h0000, test_value_o} :
        (rd_addr_i == `GST_ADDR_SIGNATURE) ? {sig_hi_q, expected_sig_o} :
        rd_slot ? {27'h0000000, slot_q[rd_addr_i[4:0]]} : 32'h00000000;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o   <= 32'h00000000;
            fifo_word_o <= 16'h0000;
        end else if (ce_i) begin
            rd_data_o   <= rd_d;
            fifo_word_o <= fifo_d;
        end
    end

    // checks
    a_start_clears: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && wr_start) |=> (ld_clear_o && state_q == GST_LD_RUN))
        else $error("start write did not restart detector");
    a_expire_done: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && expire && !wr_start) |=> status_o[1])
        else $error("expiry did not set status bit");
    a_interval_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && wr_start) |=> count_q == {1'b0, $past(ld_interval_i)} + 17'h2)
        else $error("interval count not loaded plus two");
    a_test_value: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && wr_tval) |=> test_value_o == $past(wr_data_i[15:0]))
        else $error("test value not stored");
    a_eni_level: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && !eni_strobe_sel_i[0])
        |=> input_enable_strobe_o[0] == $past(eni_level_i[0]))
        else $error("level enable not followed");
    a_eni_strobe: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && eni_strobe_sel_i[1]) |=>
        input_enable_strobe_o[1] == $past(wr_eni))
        else $error("strobe enable wrong");
    a_sync_width: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && wr_sync) ##1 (ce_i && !wr_sync && !wr_loop)
        |-> sync_output_pin_o ##1 !sync_output_pin_o)
        else $error("sync pulse not one clock");
    a_loop_feed: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && wr_loop) |=> (sync_output_pin_o && sync_in_o))
        else $error("loopback pulse missing");
    a_sig_upper: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && bist_done_i) |=> sig_hi_q == $past(bist_sig_i))
        else $error("signature upper half not captured");
    a_slot_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && wr_slot) |=>
        slot_q[$past(wr_addr_i[4:0])] == $past(wr_data_i[4:0]))
        else $error("read order slot not written");
    a_free_run: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && ld_free_run_i) |=> ld_accum_en_o)
        else $error("free run stopped accumulating");
    a_clear_pulse: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && !wr_start) |=> !ld_clear_o)
        else $error("detector clear wider than one clock");
    a_done_cleared: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && wr_start && !expire) |=> !status_o[1])
        else $error("start write left done flag set");
    a_eni_single: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && eni_strobe_sel_i[2] && !wr_eni)
        |=> !input_enable_strobe_o[2])
        else $error("strobe enable held beyond one clock");
    a_fifo_i_upper: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && cur_type == `GST_DT_I_HI)
        |=> fifo_word_o == $past(cd.i_path[23:8]))
        else $error("fifo word not upper in-phase bits");
    a_fifo_gain: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (ce_i && cur_type == `GST_DT_AGC)
        |=> fifo_word_o == $past(cd.agc_gain))
        else $error("fifo word not gain bits");
endmodule : gst_regs
`default_nettype wire

/* File: gst_consts.svh */
// constants for the global strobe and test register bank
`ifndef GST_CONSTS_SVH
`define GST_CONSTS_SVH
`define GST_ADDR_LD_START   16'hF806
`define GST_ADDR_TEST_VAL   16'hF807
`define GST_ADDR_TEST_ENI   16'hF808
`define GST_ADDR_SYNC_OUT   16'hF809
`define GST_ADDR_SYNC_LOOP  16'hF80A
`define GST_ADDR_SIGNATURE  16'hF80B
`define GST_ADDR_SLOT_BASE  16'hF820
`define GST_SLOT_BASE_HI    11'h7C1
`define GST_LD_EXTRA        17'h00002
`define GST_LD_LAST         17'h00001
`define GST_STATUS_DONE_BIT 1
`define GST_CHAN_MSB        4
`define GST_CHAN_LSB        3
`define GST_DT_MSB          2
`define GST_DT_I_HI         3'h0
`define GST_DT_I_LO         3'h1
`define GST_DT_Q_HI         3'h2
`define GST_DT_Q_LO         3'h3
`define GST_DT_MAG_HI       3'h4
`define GST_DT_MAG_LO       3'h5
`define GST_DT_PHASE        3'h6
`define GST_DT_AGC          3'h7
`endif

/* File: gst_pkg.sv */
// types for the global strobe and test register bank
package gst_pkg;
    typedef struct packed {
        logic [23:0] i_path;
        logic [23:0] q_path;
        logic [23:0] magnitude;
        logic [15:0] phase;
        logic [15:0] agc_gain;
    } gst_chan_data_t;

    typedef enum logic [1:0] {
        GST_LD_IDLE = 2'b00,
        GST_LD_RUN  = 2'b01,
        GST_LD_DONE = 2'b10
    } gst_ld_state_t;
endpackage : gst_pkg

/* File: gst_host.sv */
// host write bus model and board sync wiring
`timescale 1ns/1ns
`default_nettype none
module gst_host (
    // clock
    input  wire logic        mclk_i,
    // write bus
    output logic             wr_en_o,
    output logic      [15:0] wr_addr_o,
    output logic      [31:0] wr_data_o,
    // sync wiring
    input  wire logic        sync_out_i,
    output logic             sync_in_o
);
    logic [1:0] sync_pipe_q;
    // idle bus at time zero
    initial begin
        wr_en_o     = 1'b0;
        wr_addr_o   = 16'h0000;
        wr_data_o   = 32'h0000_0000;
    end
    always @(posedge mclk_i) begin
        sync_pipe_q <= {sync_pipe_q[0], sync_out_i};
    end
    assign sync_in_o = sync_pipe_q[1];
    // one write cycle, driven at the falling edge
    task automatic write(input logic [15:0] addr, input logic [31:0] data);
        @(negedge mclk_i);
        wr_en_o   = 1'b1;
        wr_addr_o = addr;
        wr_data_o = data;
        @(negedge mclk_i);
        wr_en_o   = 1'b0;
        wr_addr_o = ~addr;
        wr_data_o = ~data;
    endtask : write
endmodule : gst_host
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the strobe and test register bank
`include "gst_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import gst_pkg::*;
    logic           mclk_i, resetn_i, wr_en, ld_sample, ld_free_run;
    logic           sync_out, sync_pin, sync_in, ld_clear, ld_accum;
    logic           bist_done, ce;
    logic [15:0]    wr_addr, rd_addr, ld_interval, bist_sig, status;
    logic [15:0]    test_value, exp_sig, fifo_word;
    logic [31:0]    wr_data, rd_data;
    logic [3:0]     eni_sel, eni_level, eni_strobe;
    logic [4:0]     slot_sel;
    gst_chan_data_t chan_data [4];
    int             bad_count, n_compared;

    gst_host i_gst_host (.mclk_i(mclk_i), .wr_en_o(wr_en),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .sync_out_i(sync_out),
        .sync_in_o(sync_pin));
    gst_regs i_gst_regs (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce),
        .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
        .rd_addr_i(rd_addr), .rd_data_o(rd_data), .ld_sample_i(ld_sample),
        .ld_interval_i(ld_interval), .ld_free_run_i(ld_free_run),
        .ld_clear_o(ld_clear), .ld_accum_en_o(ld_accum), .status_o(status),
        .eni_strobe_sel_i(eni_sel), .eni_level_i(eni_level),
        .test_value_o(test_value), .input_enable_strobe_o(eni_strobe),
        .sync_output_pin_o(sync_out), .sync_input_pin_i(sync_pin),
        .sync_in_o(sync_in), .bist_done_i(bist_done), .bist_sig_i(bist_sig),
        .expected_sig_o(exp_sig), .slot_sel_i(slot_sel),
        .chan_data_i(chan_data), .fifo_word_o(fifo_word));

    task automatic tick();
        @(negedge mclk_i);
    endtask : tick
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_bit(input string what, input logic exp, got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        rd_addr = a;
        tick();
        chk("readback", exp, rd_data);
    endtask : rd
    task automatic pulse();
        ld_sample = 1'b1;
        tick();
        ld_sample = 1'b0;
        tick();
    endtask : pulse
    // expected word for a slot selector
    function automatic logic [15:0] exp_word(input logic [4:0] s);
        gst_chan_data_t d;
        d = chan_data[s[4:3]];
        case (s[2:0])
            3'h0: exp_word = d.i_path[23:8];
            3'h1: exp_word = {d.i_path[7:0], 8'h00};
            3'h2: exp_word = d.q_path[23:8];
            3'h3: exp_word = {d.q_path[7:0], 8'h00};
            3'h4: exp_word = d.magnitude[23:8];
            3'h5: exp_word = {d.magnitude[7:0], 8'h00};
            3'h6: exp_word = d.phase;
            default: exp_word = d.agc_gain;
        endcase
    endfunction : exp_word

    task automatic t_reset();
        chk_bit("sync out", 1'b0, sync_out);
        chk("status", 32'h0, {16'h0, status});
        rd(`GST_ADDR_SLOT_BASE, 32'h0);
    endtask : t_reset
    task automatic t_sync();
        i_gst_host.write(`GST_ADDR_SYNC_OUT, 32'hFFFF_FFFF);
        chk_bit("sync out", 1'b1, sync_out);
        chk_bit("sync in", 1'b0, sync_in);
        tick();
        chk_bit("sync out", 1'b0, sync_out);
        repeat (4) tick();
        chk_bit("sync in", 1'b0, sync_in);
        tick();
        chk_bit("sync in", 1'b1, sync_in);
        tick();
        chk_bit("sync in", 1'b0, sync_in);
        i_gst_host.write(`GST_ADDR_SYNC_LOOP, 32'h0);
        chk_bit("sync out", 1'b1, sync_out);
        chk_bit("sync in", 1'b1, sync_in);
        tick();
        chk_bit("sync out", 1'b0, sync_out);
    endtask : t_sync
    task automatic t_level();
        ld_interval = 16'h0000;
        i_gst_host.write(`GST_ADDR_LD_START, 32'h1234_5678);
        chk_bit("clear", 1'b1, ld_clear);
        chk_bit("accum", 1'b1, ld_accum);
        pulse();
        tick();
        chk("status", 32'h0, {16'h0, status});
        pulse();
        tick();
        chk("status", 32'h2, {16'h0, status});
        chk_bit("accum", 1'b0, ld_accum);
        ld_free_run = 1'b1;
        ld_interval = 16'h0003;
        i_gst_host.write(`GST_ADDR_LD_START, 32'h0);
        chk("status", 32'h0, {16'h0, status});
        repeat (4) pulse();
        tick();
        chk("status", 32'h0, {16'h0, status});
        pulse();
        tick();
        chk("status", 32'h2, {16'h0, status});
        chk_bit("accum", 1'b1, ld_accum);
    endtask : t_level
    task automatic t_test_input();
        i_gst_host.write(`GST_ADDR_TEST_VAL, 32'hDEAD_A5C3);
        i_gst_host.write(16'hF80C, 32'h0000_FFFF);
        chk("test value", 32'hA5C3, {16'h0, test_value});
        rd(`GST_ADDR_TEST_VAL, 32'h0000_A5C3);
        rd(16'hF80C, 32'h0);
    endtask : t_test_input
    task automatic t_freeze();
        ce = 1'b0;
        i_gst_host.write(`GST_ADDR_TEST_VAL, 32'h0000_1111);
        i_gst_host.write(`GST_ADDR_SYNC_OUT, 32'h0);
        chk_bit("sync out", 1'b0, sync_out);
        chk("test value", 32'hA5C3, {16'h0, test_value});
        ce = 1'b1;
    endtask : t_freeze
    task automatic t_enable();
        eni_sel   = 4'b0101;
        eni_level = 4'b1011;
        tick();
        tick();
        chk("enables", 32'hA, {28'h0, eni_strobe});
        i_gst_host.write(`GST_ADDR_TEST_ENI, 32'h0);
        chk("enables", 32'hF, {28'h0, eni_strobe});
        tick();
        chk("enables", 32'hA, {28'h0, eni_strobe});
    endtask : t_enable
    task automatic t_signature();
        i_gst_host.write(`GST_ADDR_SIGNATURE, 32'hFFFF_1234);
        chk("expected sig", 32'h1234, {16'h0, exp_sig});
        bist_sig  = 16'hBEEF;
        bist_done = 1'b1;
        tick();
        bist_done = 1'b0;
        bist_sig  = 16'h0000;
        rd(`GST_ADDR_SIGNATURE, 32'hBEEF_1234);
    endtask : t_signature
    task automatic t_slots();
        logic [4:0] idx, sel;
        for (int k = 0; k < 9; k++) begin
            idx = (k == 8) ? 5'h1F : 5'(k);
            sel = (k == 8) ? 5'h1E : {k[1:0], k[2:0]};
            i_gst_host.write(`GST_ADDR_SLOT_BASE + {11'h0, idx},
                             32'hFFFF_FFE0 | {27'h0, sel});
            slot_sel = idx;
            rd(`GST_ADDR_SLOT_BASE + {11'h0, idx}, {27'h0, sel});
            chk("fifo word", {16'h0, exp_word(sel)}, {16'h0, fifo_word});
        end
    endtask : t_slots

    task automatic summarize();
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // 100 ns clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // main sequence
    initial begin
        resetn_i = 1'b0; ld_sample = 1'b0; ld_free_run = 1'b0;
        bist_done = 1'b0; rd_addr = 16'h0000; ld_interval = 16'h0000;
        bist_sig = 16'h0000; eni_sel = 4'h0; eni_level = 4'h0;
        slot_sel = 5'h00; bad_count = 0; n_compared = 0; ce = 1'b1;
        for (int c = 0; c < 4; c++) begin
            chan_data[c] = {24'hA1B2C3, 24'hD4E5F6, 24'h172839, 16'h4A5B,
                            16'h6C7D} ^ {13{8'(c * 17)}};
        end
        repeat (8) @(negedge mclk_i);
        resetn_i = 1'b1;
        t_reset();
        t_sync();
        t_level();
        t_test_input();
        t_freeze();
        t_enable();
        t_signature();
        t_slots();
        summarize();
    end
    // watchdog well beyond the hundred or so cycles needed
    initial begin
        repeat (3000) @(posedge mclk_i);
        bad_count++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
